// File: logic/tms_core.v
// Purpose: system coprocessor translation maintenance and status restore
// Assumes: pipeline presents one instruction word with a one-cycle valid
// Notes: all updates land on the clock edge that takes the instruction
// Contract
// - restore from exception copies previous enable and mode into current.
// - restore also copies old pair into previous, bits 5..2 shift down two.
// - restore leaves the old enable and mode bits themselves unchanged.
// - probe searches entries for entry-high and loads index with position.
// - a probe miss sets the top bit of the index register.
// - probe checks all 64 entries, virtual page 63..44 against 31..12.
// - a candidate matches if global bit 8 or process id 43..38 = 11..6.
// - on a hit index holds the number in 13..8 and all else is zero.
// - several matches or references right after a probe are unspecified.
// - indexed read loads entry-high and entry-low from the indexed entry.
// - indexed write stores entry-high and entry-low into indexed entry.
// - random write stores entry-high and entry-low at random 13..8.
// - without the translation buffer these operations are undefined.
`timescale 1ns/10ps
`include "tms_map.vh"
module tms_core #(
  parameter ENTRIES = 64,
  parameter IDX_W = 6,
  parameter HAS_TLB = 1
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire instr_valid_i,
  input wire [31:0] instr_i,
  input wire [31:0] random_i,
  input wire wr_entry_high_i,
  input wire wr_entry_low_i,
  input wire wr_index_i,
  input wire wr_state_i,
  input wire [31:0] wr_data_i,
  output reg [31:0] entry_high_reg_o,
  output reg [31:0] entry_low_reg_o,
  output reg [31:0] index_reg_o,
  output reg [31:0] processor_state_reg_o,
  output wire undefined_op_o,
  output wire op_done_o
);
  reg [63:0] entry_q [0:ENTRIES-1];
  reg [31:0] entry_high_reg_q;
  reg [31:0] entry_low_reg_q;
  reg [31:0] index_reg_q;
  reg [31:0] processor_state_reg_q;

  // next values, one combinational process per register
  reg [31:0] entry_high_reg_d;
  reg [31:0] entry_low_reg_d;
  reg [31:0] index_reg_d;
  reg [31:0] processor_state_reg_d;

  // index value a probe would leave behind, hit or miss
  reg [31:0] probe_index;

  // status word as it stands after a restore
  reg [31:0] state_shifted;

  // the two stacked enable and mode pairs that a restore moves
  wire old_kernel_user = processor_state_reg_q[5];
  wire old_irq_enable = processor_state_reg_q[4];
  wire previous_kernel_user = processor_state_reg_q[3];
  wire previous_irq_enable = processor_state_reg_q[2];

  wire [ENTRIES*64-1:0] flat;
  wire hit;
  wire [IDX_W-1:0] hit_idx;
  wire [5:0] fn = instr_i[5:0];
  wire is_cop = instr_valid_i &&
      (instr_i[`TMS_OPC_HI:`TMS_OPC_LO] == `TMS_SYS_COP_OPCODE) &&
      instr_i[`TMS_COP_OP_BIT];
  wire has_tlb = (HAS_TLB != 0);
  wire do_probe = is_cop && has_tlb && (fn == `TMS_FN_PROBE);
  wire do_read = is_cop && has_tlb && (fn == `TMS_FN_READ);
  wire do_wri = is_cop && has_tlb && (fn == `TMS_FN_WRITE_IDX);
  wire do_wrr = is_cop && has_tlb && (fn == `TMS_FN_WRITE_RND);
  wire do_rfe = is_cop && (fn == `TMS_FN_RESTORE);
  wire [IDX_W-1:0] sel_idx = index_reg_q[`TMS_IDX_HI:`TMS_IDX_LO];
  wire [IDX_W-1:0] rnd_idx = random_i[`TMS_IDX_HI:`TMS_IDX_LO];
  wire [63:0] rd_entry = entry_q[sel_idx];

  assign undefined_op_o = is_cop && !(do_probe || do_read || do_wri ||
      do_wrr || do_rfe);
  assign op_done_o = do_probe || do_read || do_wri || do_wrr || do_rfe;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
      // per-entry write selects; indexed and random writes never
      // decode together, so their order here is only for form
      wire wr_idx_sel = do_wri && (sel_idx == g);
      wire wr_rnd_sel = do_wrr && (rnd_idx == g);

      assign flat[g*64 +: 64] = entry_q[g];

      always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          entry_q[g] <= `TMS_ENTRY_RST;
        end else if (wr_idx_sel) begin
          entry_q[g] <= {entry_high_reg_q, entry_low_reg_q};
        end else if (wr_rnd_sel) begin
          entry_q[g] <= {entry_high_reg_q, entry_low_reg_q};
        end
      end
    end
  endgenerate

  tms_match #(
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) u_match (
    .entries_i(flat),
    .entry_high_i(entry_high_reg_q),
    .hit_o(hit),
    .hit_idx_o(hit_idx)
  );

  // a decoded operation beats a move-to strobe aimed at the same
  // register in the same cycle, so software sees the operation's result
  always @* begin
    entry_high_reg_d = entry_high_reg_q;
    if (do_read) begin
      entry_high_reg_d = rd_entry[63:32];
    end else if (wr_entry_high_i) begin
      entry_high_reg_d = wr_data_i;
    end
  end

  always @* begin
    entry_low_reg_d = entry_low_reg_q;
    if (do_read) begin
      entry_low_reg_d = rd_entry[31:0];
    end else if (wr_entry_low_i) begin
      entry_low_reg_d = wr_data_i;
    end
  end

  // miss sets only the top bit; a hit clears the flag and all else but the number in 13..8
  always @* begin
    probe_index = `TMS_IDX_MISS_VAL;
    if (hit) begin
      probe_index = `TMS_IDX_CLR;
      probe_index[`TMS_IDX_HI:`TMS_IDX_LO] = hit_idx;
    end
  end

  always @* begin
    index_reg_d = index_reg_q;
    if (do_probe) begin
      index_reg_d = probe_index;
    end else if (wr_index_i) begin
      index_reg_d = wr_data_i;
    end
  end

  // current pair takes previous, previous takes old, old stays put
  always @* begin
    state_shifted = {processor_state_reg_q[31:6],
        old_kernel_user, old_irq_enable,
        old_kernel_user, old_irq_enable,
        previous_kernel_user, previous_irq_enable};
    processor_state_reg_d = processor_state_reg_q;
    if (do_rfe) begin
      processor_state_reg_d = state_shifted;
    end else if (wr_state_i) begin
      processor_state_reg_d = wr_data_i;
    end
  end

  // every result lands on the edge that takes the instruction,
  // so the very next instruction already sees it
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      entry_high_reg_q <= `TMS_STATE_RST;
      entry_low_reg_q <= `TMS_STATE_RST;
      index_reg_q <= `TMS_STATE_RST;
      processor_state_reg_q <= `TMS_STATE_RST;
    end else begin
      entry_high_reg_q <= entry_high_reg_d;
      entry_low_reg_q <= entry_low_reg_d;
      index_reg_q <= index_reg_d;
      processor_state_reg_q <= processor_state_reg_d;
    end
  end

  always @* begin
    entry_high_reg_o = entry_high_reg_q;
    entry_low_reg_o = entry_low_reg_q;
    index_reg_o = index_reg_q;
    processor_state_reg_o = processor_state_reg_q;
  end
endmodule // tms_core

// File: logic/tms_map.vh
// Purpose: constants for the translation maintenance and status restore block
// Assumes: 32-bit coprocessor instruction word, 64-entry translation buffer
// Notes: definitions only
`ifndef TMS_MAP_VH
`define TMS_MAP_VH
`define TMS_OPC_HI 31
`define TMS_OPC_LO 26
`define TMS_SYS_COP_OPCODE 6'h10
`define TMS_COP_OP_BIT 25
`define TMS_FN_READ 6'h01
`define TMS_FN_WRITE_IDX 6'h02
`define TMS_FN_WRITE_RND 6'h06
`define TMS_FN_PROBE 6'h08
`define TMS_FN_RESTORE 6'h10
`define TMS_IDX_HI 13
`define TMS_IDX_LO 8
`define TMS_IDX_MISS 31
`define TMS_IDX_MISS_VAL 32'h80000000
`define TMS_IDX_CLR 32'h00000000
`define TMS_VPN_HI 63
`define TMS_VPN_LO 44
`define TMS_PID_HI 43
`define TMS_PID_LO 38
`define TMS_GLOBAL 8
`define TMS_EH_VPN_HI 31
`define TMS_EH_VPN_LO 12
`define TMS_EH_PID_HI 11
`define TMS_EH_PID_LO 6
`define TMS_STATE_RST 32'h00000000
`define TMS_ENTRY_RST 64'h0000000000000000
`endif

// File: logic/tms_match.v
// Purpose: parallel match of entry-high against every translation entry
// Assumes: entries packed flat, entry n at bits n*64 +: 64
// Notes: lowest matching entry wins; several matches are unspecified
`timescale 1ns/10ps
`include "tms_map.vh"
module tms_match #(
  parameter ENTRIES = 64,
  parameter IDX_W = 6
) (
  input wire [ENTRIES*64-1:0] entries_i,
  input wire [31:0] entry_high_i,
  output reg hit_o,
  output reg [IDX_W-1:0] hit_idx_o
);
  wire [ENTRIES-1:0] match;
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_cmp
      wire [63:0] e = entries_i[g*64 +: 64];
      assign match[g] = (e[`TMS_VPN_HI:`TMS_VPN_LO] ==
          entry_high_i[`TMS_EH_VPN_HI:`TMS_EH_VPN_LO]) &&
          (e[`TMS_GLOBAL] || (e[`TMS_PID_HI:`TMS_PID_LO] ==
          entry_high_i[`TMS_EH_PID_HI:`TMS_EH_PID_LO]));
    end
  endgenerate
  integer i;
  always @* begin
    hit_o = 1'b0;
    hit_idx_o = {IDX_W{1'b0}};
    for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
      if (match[i]) begin
        hit_o = 1'b1;
        hit_idx_o = i[IDX_W-1:0];
      end
    end
  end
endmodule // tms_match

// File: verif/testbench.sv
// Purpose: directed ops. Assumes: op taken after go. Notes: entries 5 and 9
`timescale 1ns/10ps
module testbench;
  reg clk = 1'b0, rstn = 1'b0;
  reg [10:0] ctl = 11'h000;
  reg [31:0] wd = 32'h0;
  wire v, und, dn;
  wire [31:0] ins, eh, el, ix, st;
  integer n_fail = 0, n_checks = 0;
  initial forever #50 clk = ~clk;
  tms_pipe u_pipe (.go_i(ctl[4]), .fn_i(ctl[10:5]), .vld_o(v), .ins_o(ins));
  tms_core u_dut (.sys_clk_i(clk), .rstn_i(rstn), .instr_valid_i(v),
    .instr_i(ins), .random_i(32'h00000900), .wr_entry_high_i(ctl[0]),
    .wr_entry_low_i(ctl[1]), .wr_index_i(ctl[2]), .wr_state_i(ctl[3]),
    .wr_data_i(wd), .entry_high_reg_o(eh), .entry_low_reg_o(el),
    .index_reg_o(ix), .processor_state_reg_o(st), .undefined_op_o(und),
    .op_done_o(dn));
  task cmp(input [39:0] nm, input [31:0] e, g);
    n_checks = n_checks + 1;
    n_fail = n_fail + (g !== e);
    if (g !== e) $display("[FAIL] %0s exp %h got %h", nm, e, g);
  endtask
  task io(input [3:0] w, input [31:0] d, input g, input [5:0] f);
    ctl <= {f, g, w};
    wd <= d;
    #1 if (g) cmp("undef", {31'h0, f == 6'h3f}, {31'h0, und});
    if (g) cmp("done", {31'h0, f != 6'h3f}, {31'h0, dn});
    @(posedge clk) ctl[4:0] <= 5'h00;
    @(posedge clk);
  endtask
  task final_report;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    io(4'h1, 32'h123450c0, 1'b0, 6'h00);
    io(4'h4, 32'h00000500, 1'b0, 6'h00);
    io(4'h0, 32'h0, 1'b1, 6'h02);
    io(4'h1, 32'habcde040, 1'b0, 6'h00);
    io(4'h2, 32'h00000100, 1'b0, 6'h00);
    io(4'h0, 32'h0, 1'b1, 6'h06);
    io(4'h0, 32'h0, 1'b1, 6'h01);
    cmp("rd hi", 32'h123450c0, eh);
    io(4'h0, 32'h0, 1'b1, 6'h08);
    cmp("hit", 32'h00000500, ix);
    io(4'h1, 32'h12345080, 1'b0, 6'h00);
    io(4'h0, 32'h0, 1'b1, 6'h08);
    cmp("miss", 32'h80000000, ix);
    io(4'h1, 32'habcdefc0, 1'b0, 6'h00);
    io(4'h0, 32'h0, 1'b1, 6'h08);
    io(4'h0, 32'h0, 1'b1, 6'h01);
    cmp("glob", 32'h00000100, el);
    io(4'h8, 32'h00000034, 1'b0, 6'h00);
    io(4'h0, 32'h0, 1'b1, 6'h10);
    cmp("back", 32'h0000003d, st);
    io(4'h0, 32'h0, 1'b1, 6'h3f);
    final_report;
  end
endmodule // testbench
bind tms_core tms_chk u_chk (.*);

// File: verif/tms_core_chk.sv
// Purpose: port checks. Assumes: one clock. Notes: bound in the testbench
`timescale 1ns/10ps
module tms_chk (
  input wire sys_clk_i, input wire rstn_i, input wire instr_valid_i,
  input wire [31:0] instr_i, input wire wr_entry_high_i,
  input wire wr_index_i, input wire wr_state_i, input wire undefined_op_o,
  input wire [31:0] entry_high_reg_o, input wire [31:0] index_reg_o,
  input wire [31:0] processor_state_reg_o, input wire op_done_o);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire op = instr_valid_i && instr_i[31:25] == 7'h21;
  wire kn = instr_i[5:0] inside {6'h01, 6'h02, 6'h06, 6'h08, 6'h10};
  wire [31:0] st = processor_state_reg_o;
  sequence back_s; op && instr_i[5:0] == 6'h10; endsequence
  sequence prb_s; op && instr_i[5:0] == 6'h08; endsequence
  shift_a: assert property (back_s |=>
    st == {$past(st[31:4]), $past(st[5:2])}) else $error("shift");
  old_a: assert property (back_s |=> st[5:4] == st[3:2])
    else $error("old bits");
  probe_a: assert property (prb_s |=>
    index_reg_o == 32'h80000000 || (index_reg_o & 32'hffffc0ff) == 32'h0)
    else $error("index form");
  idx_a: assert property (op && instr_i[5:0] != 6'h08 && !wr_index_i
    |=> $stable(index_reg_o)) else $error("index moved");
  eh_a: assert property (prb_s && !wr_entry_high_i
    |=> $stable(entry_high_reg_o))
    else $error("high moved");
  hold_a: assert property (!instr_valid_i && !wr_state_i
    |=> $stable(st)) else $error("state moved");
  done_a: assert property (op_done_o == (op && kn))
    else $error("done");
  undef_a: assert property (undefined_op_o == (op && !kn))
    else $error("undef");
endmodule // tms_chk

// File: verif/tms_pipe.sv
// Purpose: pipeline issuing ops. Assumes: go is one cycle. Notes: idle inverts
`timescale 1ns/10ps
module tms_pipe (input wire go_i, input wire [5:0] fn_i,
  output wire vld_o, output wire [31:0] ins_o);
  assign vld_o = go_i;
  assign ins_o = {7'h21, 19'h00000, fn_i} ^ {32{~go_i}};
endmodule // tms_pipe
